// File: hw/com_consts.svh
`ifndef COM_CONSTS_SVH
`define COM_CONSTS_SVH

// =====================================================================
// Opcode classification
`define COM_ESC_PATTERN     5'h1b
`define COM_MODE_NODISP     2'h0
`define COM_MODE_DISP8      2'h1
`define COM_MODE_DISP16     2'h2
`define COM_MODE_REG        2'h3
`define COM_RM_DIRECT       3'h6

// =====================================================================
// Queue status codes {high, low}
`define COM_QS_NONE         2'h0
`define COM_QS_FIRST        2'h1
`define COM_QS_NEXT         2'h2
`define COM_QS_RSVD         2'h3

// =====================================================================
// Bus cycle status codes
`define COM_BS_FETCH        3'h4
`define COM_BS_READ         3'h5
`define COM_BS_PASSIVE      3'h7

// =====================================================================
// Sizes and reset values
`define COM_QUEUE_DEPTH     3'h6
`define COM_QUEUE_LAST      3'h5
`define COM_STACK_DEPTH     8
`define COM_ADDR_RESET      20'h0_0000
`define COM_WORD_RESET      16'h0000
`define COM_FREG_RESET      80'h0

`endif

// File: hw/com_dev.sv
// Behaviour
// RL1: Opcode top five bits 11011 means coprocessor
// RL2: Fetches via bus; execution via queue status
// RL3: Non-memory form: nine bits select function
// RL4: Memory form: six bits give operand action
// RL5: Mode bits 7:6 of next byte mark memory
// RL6: Mode plus r/m give displacement byte count
// RL7: Host does no bus cycle on non-memory
// RL8: Host reads word at effective address
// RL9: Host discards dummy read data
// RL10: Host registers unchanged except pointer advance
// RL11: Host treats opcode as no-operation otherwise
// RL12: Dummy read gives address and one word
// RL13: Eight 80-bit floating-point stack registers
// RL14: Queue status: none, first, next, reserved
// RL15: Capture address and data of dummy read
// RL16: Drop bytes of non-coprocessor instructions
`timescale 1ns/1ns
`include "com_consts.svh"

module com_dev (
    input  wire logic                CLK,
    input  wire logic                RSTN,
    com_if.cop                       link,
    output      logic                FUNC_VALID,
    output      com_pkg::com_func_t  FUNC_CODE,
    output      logic                MEMOP_VALID,
    output      com_pkg::com_mop_t   MEMOP_CODE,
    output      com_pkg::com_addr_t  MEMOP_ADDR,
    output      com_pkg::com_word_t  MEMOP_DATA,
    output      logic                BUSY,
    input  wire logic                STACK_WE,
    input  wire com_pkg::com_sel_t   STACK_WSEL,
    input  wire com_pkg::com_freg_t  STACK_WDATA,
    input  wire com_pkg::com_sel_t   STACK_RSEL,
    output      com_pkg::com_freg_t  STACK_RDATA
);
    import com_pkg::*;

    // =================================================================
    // Instruction queue mirroring the host prefetch queue
    com_byte_t      queue [`COM_QUEUE_DEPTH];
    logic [2:0]     wr_ptr;
    logic [2:0]     rd_ptr;
    logic [2:0]     count;
    logic [1:0]     qs;
    logic           push_req;
    logic           pop_req;
    logic           pop_ok;
    logic           push_ok;
    logic           is_first;
    logic           is_next;
    com_byte_t      top;

    assign qs       = {link.queue_status_high, link.queue_status_low};
    assign push_req = link.bus_cycle_status == `COM_BS_FETCH;     // [RL2]
    assign pop_req  = (qs == `COM_QS_FIRST) || (qs == `COM_QS_NEXT); // [RL14]
    assign pop_ok   = pop_req && (count != 3'h0);
    assign push_ok  = push_req && ((count != `COM_QUEUE_DEPTH) || pop_ok);
    assign is_first = pop_ok && (qs == `COM_QS_FIRST);             // [RL14]
    assign is_next  = pop_ok && (qs == `COM_QS_NEXT);              // [RL14]
    assign top      = queue[rd_ptr];

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            count  <= 3'h0;
        end else begin
            if (push_ok) begin
                wr_ptr <= (wr_ptr == `COM_QUEUE_LAST) ? 3'h0 : wr_ptr + 3'h1;
            end
            if (pop_ok) begin
                rd_ptr <= (rd_ptr == `COM_QUEUE_LAST) ? 3'h0 : rd_ptr + 3'h1;
            end
            count <= count + {2'h0, push_ok} - {2'h0, pop_ok};
        end
    end

    // Queue storage carries no reset; entries are written before read
    always_ff @(posedge CLK) begin
        if (push_ok) begin
            queue[wr_ptr] <= link.bus_data[7:0];                   // [RL2]
        end
    end

    // =================================================================
    // Opcode decode
    com_dev_state_t state;
    com_dev_state_t next_state;
    logic           top_is_esc;
    logic [1:0]     top_mode;
    logic [2:0]     top_rm;
    logic [1:0]     disp_need;
    logic [1:0]     disp_left;
    logic [2:0]     opc_low;
    logic [2:0]     op_reg;
    logic           modrm_take;
    logic           func_fire;
    logic           disp_take;
    logic           rd_hit;

    assign top_is_esc = top[7:3] == `COM_ESC_PATTERN;              // [RL1]
    assign top_mode   = top[7:6];                                  // [RL5]
    assign top_rm     = top[2:0];
    assign disp_need  = (top_mode == `COM_MODE_DISP8)  ? 2'h1 :    // [RL6]
                        (top_mode == `COM_MODE_DISP16) ? 2'h2 :
                        (top_mode == `COM_MODE_NODISP &&
                         top_rm == `COM_RM_DIRECT)     ? 2'h2 : 2'h0;
    assign modrm_take = (state == DEV_MODRM) && is_next;
    assign func_fire  = modrm_take && (top_mode == `COM_MODE_REG); // [RL5]
    assign disp_take  = (state == DEV_DISP) && is_next;
    assign rd_hit     = (state == DEV_RDWAIT) &&
                        (link.bus_cycle_status == `COM_BS_READ);   // [RL12]

    always_comb begin
        next_state = state;
        if (is_first) begin
            // Non-coprocessor bytes are thrown away until next first
            next_state = top_is_esc ? DEV_MODRM : DEV_SKIP;        // [RL16]
        end else begin
            case (state)
                DEV_IDLE: begin
                    next_state = DEV_IDLE;
                end
                DEV_SKIP: begin
                    next_state = DEV_SKIP;                         // [RL16]
                end
                DEV_MODRM: begin
                    if (modrm_take) begin
                        if (top_mode == `COM_MODE_REG) begin
                            next_state = DEV_IDLE;
                        end else if (disp_need == 2'h0) begin
                            next_state = DEV_RDWAIT;
                        end else begin
                            next_state = DEV_DISP;                 // [RL6]
                        end
                    end
                end
                DEV_DISP: begin
                    if (disp_take && disp_left == 2'h1) begin
                        next_state = DEV_RDWAIT;
                    end
                end
                DEV_RDWAIT: begin
                    if (rd_hit) begin
                        next_state = DEV_IDLE;
                    end
                end
                default: begin
                    next_state = DEV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state     <= DEV_IDLE;
            opc_low   <= 3'h0;
            op_reg    <= 3'h0;
            disp_left <= 2'h0;
        end else begin
            state <= next_state;
            if (is_first) begin
                opc_low <= top[2:0];
            end
            if (modrm_take) begin
                op_reg    <= top[5:3];
                disp_left <= disp_need;                            // [RL6]
            end else if (disp_take) begin
                disp_left <= disp_left - 2'h1;
            end
        end
    end

    // =================================================================
    // Results toward the arithmetic unit
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            FUNC_VALID  <= 1'b0;
            FUNC_CODE   <= 9'h000;
            MEMOP_VALID <= 1'b0;
            MEMOP_CODE  <= 6'h00;
            MEMOP_ADDR  <= `COM_ADDR_RESET;
            MEMOP_DATA  <= `COM_WORD_RESET;
            BUSY        <= 1'b0;
        end else begin
            FUNC_VALID  <= func_fire;
            MEMOP_VALID <= rd_hit;
            BUSY        <= (next_state == DEV_MODRM) ||
                           (next_state == DEV_DISP) ||
                           (next_state == DEV_RDWAIT);
            if (func_fire) begin
                FUNC_CODE <= {opc_low, top[5:0]};                  // [RL3]
            end
            if (rd_hit) begin
                MEMOP_CODE <= {opc_low, op_reg};                   // [RL4]
                MEMOP_ADDR <= link.bus_addr;                       // [RL15]
                MEMOP_DATA <= link.bus_data;                       // [RL15]
            end
        end
    end

    // =================================================================
    // Floating-point register stack
    com_freg_t fregs [`COM_STACK_DEPTH];

    generate
        for (genvar i = 0; i < `COM_STACK_DEPTH; i++) begin : g_freg
            always_ff @(posedge CLK) begin
                if (!RSTN) begin
                    fregs[i] <= `COM_FREG_RESET;                   // [RL13]
                end else if (STACK_WE && STACK_WSEL == com_sel_t'(i)) begin
                    fregs[i] <= STACK_WDATA;                       // [RL13]
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            STACK_RDATA <= `COM_FREG_RESET;
        end else begin
            STACK_RDATA <= fregs[STACK_RSEL];
        end
    end

endmodule : com_dev

// File: hw/com_host.sv
`timescale 1ns/1ns
`include "com_consts.svh"

module com_host (
    input  wire logic                CLK,
    input  wire logic                RSTN,
    com_if.host                      link,
    input  wire logic                INSTR_VALID,
    output      logic                INSTR_READY,
    input  wire logic [31:0]         INSTR_BYTES,
    input  wire logic [2:0]          INSTR_LEN,
    input  wire com_pkg::com_addr_t  BASE_ADDR,
    output      logic                MEM_RD,
    output      com_pkg::com_addr_t  MEM_ADDR,
    input  wire com_pkg::com_word_t  MEM_RDATA,
    output      logic                DONE,
    output      com_pkg::com_addr_t  IP_OUT
);
    import com_pkg::*;

    // =================================================================
    // Instruction classification at acceptance
    com_hst_state_t state;
    logic [31:0]    ibuf;
    logic [2:0]     len;
    logic [2:0]     cnt;
    logic           mem_form;
    com_addr_t      ea;
    com_addr_t      ip;
    logic           accept;
    logic           in_esc;
    logic [1:0]     in_mode;
    logic [1:0]     in_disp;
    com_addr_t      in_dext;
    logic [2:0]     in_len;
    com_byte_t      cur_byte;

    assign INSTR_READY = state == HST_IDLE;
    assign accept      = INSTR_READY && INSTR_VALID;
    assign in_esc      = INSTR_BYTES[7:3] == `COM_ESC_PATTERN;
    assign in_mode     = INSTR_BYTES[15:14];                       // [RL5]
    assign in_disp     = (in_mode == `COM_MODE_DISP8)  ? 2'h1 :    // [RL6]
                         (in_mode == `COM_MODE_DISP16) ? 2'h2 :
                         (in_mode == `COM_MODE_NODISP &&
                          INSTR_BYTES[10:8] == `COM_RM_DIRECT) ? 2'h2 :
                         2'h0;
    assign in_dext     = (in_disp == 2'h1) ?
                         {{12{INSTR_BYTES[23]}}, INSTR_BYTES[23:16]} :
                         (in_disp == 2'h2) ?
                         {{4{INSTR_BYTES[31]}}, INSTR_BYTES[31:16]} :
                         `COM_ADDR_RESET;
    assign in_len      = in_esc ? 3'h2 + {1'b0, in_disp} : INSTR_LEN;
    assign cur_byte    = ibuf[{cnt[1:0], 3'h0} +: 8];
    assign MEM_RD      = state == HST_READ;                        // [RL8]
    assign MEM_ADDR    = ea;
    assign IP_OUT      = ip;

    // =================================================================
    // Sequencer: fetch, queue removal, optional dummy read
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state    <= HST_IDLE;
            ibuf     <= 32'h0000_0000;
            len      <= 3'h0;
            cnt      <= 3'h0;
            mem_form <= 1'b0;
            ea       <= `COM_ADDR_RESET;
            ip       <= `COM_ADDR_RESET;
            DONE     <= 1'b0;
        end else begin
            DONE <= 1'b0;
            case (state)
                HST_IDLE: begin
                    if (accept) begin
                        ibuf     <= INSTR_BYTES;
                        len      <= in_len;
                        cnt      <= 3'h0;
                        mem_form <= in_esc &&
                                    (in_mode != `COM_MODE_REG);    // [RL7]
                        ea       <= BASE_ADDR + in_dext;           // [RL8]
                        state    <= HST_FETCH;
                    end
                end
                HST_FETCH: begin
                    cnt <= cnt + 3'h1;
                    if (cnt == len - 3'h1) begin
                        cnt   <= 3'h0;
                        state <= HST_QFIRST;
                    end
                end
                HST_QFIRST: begin
                    cnt   <= 3'h1;
                    state <= (len == 3'h1) ? (mem_form ? HST_READ : HST_DONE)
                                           : HST_QNEXT;
                end
                HST_QNEXT: begin
                    cnt <= cnt + 3'h1;
                    if (cnt == len - 3'h1) begin
                        state <= mem_form ? HST_READ : HST_DONE;   // [RL7]
                    end
                end
                HST_READ: begin
                    state <= HST_DONE;
                end
                HST_DONE: begin
                    ip    <= ip + {17'h0_0000, len};               // [RL10]
                    DONE  <= 1'b1;                                 // [RL11]
                    state <= HST_IDLE;
                end
                default: begin
                    state <= HST_IDLE;
                end
            endcase
        end
    end

    // =================================================================
    // Local bus and queue status drive
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            link.bus_cycle_status  <= `COM_BS_PASSIVE;
            link.bus_addr          <= `COM_ADDR_RESET;
            link.bus_data          <= `COM_WORD_RESET;
            link.queue_status_low  <= 1'b0;
            link.queue_status_high <= 1'b0;
        end else begin
            link.bus_cycle_status  <= `COM_BS_PASSIVE;
            link.queue_status_low  <= 1'b0;
            link.queue_status_high <= 1'b0;
            if (state == HST_FETCH) begin
                link.bus_cycle_status <= `COM_BS_FETCH;
                link.bus_addr         <= ip + {17'h0_0000, cnt};
                link.bus_data         <= {8'h00, cur_byte};
            end
            if (state == HST_QFIRST) begin
                link.queue_status_low <= 1'b1;
            end
            if (state == HST_QNEXT) begin
                link.queue_status_high <= 1'b1;
            end
            if (state == HST_READ) begin
                // Word only shown on the bus, never kept by the host
                link.bus_cycle_status <= `COM_BS_READ;             // [RL8]
                link.bus_addr         <= ea;
                link.bus_data         <= MEM_RDATA;                // [RL9]
            end
        end
    end

endmodule : com_host

// File: hw/com_if.sv
`timescale 1ns/1ns

interface com_if;
    import com_pkg::*;

    com_status_t bus_cycle_status;
    com_addr_t   bus_addr;
    com_word_t   bus_data;
    logic        queue_status_low;
    logic        queue_status_high;

    modport host (
        output bus_cycle_status,
        output bus_addr,
        output bus_data,
        output queue_status_low,
        output queue_status_high
    );

    modport cop (
        input bus_cycle_status,
        input bus_addr,
        input bus_data,
        input queue_status_low,
        input queue_status_high
    );

endinterface : com_if

// File: hw/com_pkg.sv
package com_pkg;

    // =================================================================
    // Data types
    typedef logic [19:0] com_addr_t;
    typedef logic [15:0] com_word_t;
    typedef logic [7:0]  com_byte_t;
    typedef logic [8:0]  com_func_t;
    typedef logic [5:0]  com_mop_t;
    typedef logic [79:0] com_freg_t;
    typedef logic [2:0]  com_sel_t;
    typedef logic [2:0]  com_status_t;

    // =================================================================
    // State machines
    typedef enum logic [2:0] {
        DEV_IDLE,
        DEV_SKIP,
        DEV_MODRM,
        DEV_DISP,
        DEV_RDWAIT
    } com_dev_state_t;

    typedef enum logic [2:0] {
        HST_IDLE,
        HST_FETCH,
        HST_QFIRST,
        HST_QNEXT,
        HST_READ,
        HST_DONE
    } com_hst_state_t;

endpackage : com_pkg

// File: test/com_link_sva.sv
`timescale 1ns/1ns
`include "com_consts.svh"

module com_link_sva (
    input wire logic                 CLK,
    input wire logic                 RSTN,
    input wire com_pkg::com_status_t bus_cycle_status,
    input wire com_pkg::com_addr_t   bus_addr,
    input wire com_pkg::com_word_t   bus_data,
    input wire logic                 queue_status_low,
    input wire logic                 queue_status_high
);
    import com_pkg::*;

    wire [1:0] qs = {queue_status_high, queue_status_low};

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // =================================================================
    // Link checks
    status_legal_a: assert property (
        bus_cycle_status inside {`COM_BS_FETCH, `COM_BS_READ,
                                 `COM_BS_PASSIVE})
        else $error("bus status code outside the used set");
    qs_reserved_a: assert property (
        qs != `COM_QS_RSVD)
        else $error("reserved queue status driven");
    reset_idle_a: assert property (
        @(posedge CLK) disable iff (1'b0)
        !RSTN |=> bus_cycle_status == `COM_BS_PASSIVE && qs == `COM_QS_NONE)
        else $error("link not idle after reset");
    first_fetched_a: assert property (
        qs == `COM_QS_FIRST |-> $past(bus_cycle_status) == `COM_BS_FETCH)
        else $error("first byte taken without preceding fetch");
    next_order_a: assert property (
        qs == `COM_QS_NEXT |-> $past(qs) inside {`COM_QS_FIRST, `COM_QS_NEXT})
        else $error("subsequent byte without first byte");
    read_after_pop_a: assert property (
        bus_cycle_status == `COM_BS_READ |-> $past(qs) == `COM_QS_NEXT)
        else $error("dummy read not after last byte taken");
    read_single_a: assert property (
        bus_cycle_status == `COM_BS_READ |-> ##1
        bus_cycle_status == `COM_BS_PASSIVE)
        else $error("dummy read longer than one cycle");
    fetch_step_a: assert property (
        bus_cycle_status == `COM_BS_FETCH &&
        $past(bus_cycle_status) == `COM_BS_FETCH
        |-> bus_addr == $past(bus_addr) + 20'h0_0001)
        else $error("fetch address not incrementing");
    fetch_data_a: assert property (
        bus_cycle_status == `COM_BS_FETCH |-> bus_data[15:8] == 8'h00)
        else $error("fetch byte not on low lane");

    cover property (bus_cycle_status == `COM_BS_READ);
    cover property (qs == `COM_QS_FIRST ##1 qs == `COM_QS_NEXT ##1
                    qs == `COM_QS_NEXT);
    cover property (bus_cycle_status == `COM_BS_FETCH [*4]);

endmodule : com_link_sva

// File: test/tb.sv
`timescale 1ns/1ns
`include "com_consts.svh"

module tb;
    import com_pkg::*;

    logic        CLK;
    logic        RSTN;
    logic        INSTR_VALID;
    logic        INSTR_READY;
    logic [31:0] INSTR_BYTES;
    logic [2:0]  INSTR_LEN;
    com_addr_t   BASE_ADDR;
    logic        MEM_RD;
    com_addr_t   MEM_ADDR;
    com_word_t   MEM_RDATA;
    logic        DONE;
    com_addr_t   IP_OUT;
    logic        FUNC_VALID;
    com_func_t   FUNC_CODE;
    logic        MEMOP_VALID;
    com_mop_t    MEMOP_CODE;
    com_addr_t   MEMOP_ADDR;
    com_word_t   MEMOP_DATA;
    logic        BUSY;
    logic        STACK_WE;
    com_sel_t    STACK_WSEL;
    com_freg_t   STACK_WDATA;
    com_sel_t    STACK_RSEL;
    com_freg_t   STACK_RDATA;
    int          err_count;
    int          tests_run;
    com_addr_t   exp_ip;
    com_addr_t   rd_addr;
    logic [4:0]  saw;

    // =================================================================
    // Design and checker
    com_if com_if_inst ();
    com_host com_host_inst (.CLK(CLK), .RSTN(RSTN), .link(com_if_inst),
        .INSTR_VALID(INSTR_VALID), .INSTR_READY(INSTR_READY),
        .INSTR_BYTES(INSTR_BYTES), .INSTR_LEN(INSTR_LEN),
        .BASE_ADDR(BASE_ADDR), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR),
        .MEM_RDATA(MEM_RDATA), .DONE(DONE), .IP_OUT(IP_OUT));
    com_dev com_dev_inst (.CLK(CLK), .RSTN(RSTN), .link(com_if_inst),
        .FUNC_VALID(FUNC_VALID), .FUNC_CODE(FUNC_CODE),
        .MEMOP_VALID(MEMOP_VALID), .MEMOP_CODE(MEMOP_CODE),
        .MEMOP_ADDR(MEMOP_ADDR), .MEMOP_DATA(MEMOP_DATA), .BUSY(BUSY),
        .STACK_WE(STACK_WE), .STACK_WSEL(STACK_WSEL),
        .STACK_WDATA(STACK_WDATA), .STACK_RSEL(STACK_RSEL),
        .STACK_RDATA(STACK_RDATA));
    com_link_sva com_link_sva_inst (.CLK(CLK), .RSTN(RSTN),
        .bus_cycle_status(com_if_inst.bus_cycle_status),
        .bus_addr(com_if_inst.bus_addr), .bus_data(com_if_inst.bus_data),
        .queue_status_low(com_if_inst.queue_status_low),
        .queue_status_high(com_if_inst.queue_status_high));

    initial CLK = 1'b0;
    always #20 CLK = ~CLK;

    // =================================================================
    // Shared tasks
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic sample();
        @(negedge CLK);
        if (MEM_RD === 1'b1) begin
            saw[0]  = 1'b1;
            rd_addr = MEM_ADDR;
        end
        if (FUNC_VALID === 1'b1) saw[1] = 1'b1;
        if (MEMOP_VALID === 1'b1) saw[2] = 1'b1;
        if (DONE === 1'b1) saw[3] = 1'b1;
        if (BUSY === 1'b1) saw[4] = 1'b1;
    endtask : sample

    // Saw bits: 0 read, 1 function, 2 memory op, 3 done, 4 busy
    task automatic run(input logic [31:0] b, input logic [2:0] n,
                       input com_addr_t base, input com_word_t rd);
        int k;
        saw = 5'h00;
        @(posedge CLK);
        INSTR_BYTES <= b;
        INSTR_LEN   <= n;
        BASE_ADDR   <= base;
        MEM_RDATA   <= rd;
        INSTR_VALID <= 1'b1;
        @(negedge CLK);
        for (k = 0; k < 20 && INSTR_READY !== 1'b1; k++) @(negedge CLK);
        @(posedge CLK);
        INSTR_VALID <= 1'b0;
        for (k = 0; k < 20 && !saw[3]; k++) sample();
        for (k = 0; k < 3; k++) sample();
        exp_ip = exp_ip + 20'(n);
        check(saw[3], 1'b1);
        check(IP_OUT, exp_ip);
    endtask : run

    // =================================================================
    // Scenarios
    task automatic t_nonmem();
        logic [7:0] b1;
        for (int i = 0; i < 8; i++) begin
            b1 = {2'h3, 3'(i), 3'(7 - i)};
            run({16'h0000, b1, 5'h1b, 3'(i)}, 3'h2, 20'h0_1000, 16'haaaa);
            check(saw[0], 1'b0);
            check(saw[1], 1'b1);
            check(saw[2], 1'b0);
            check(FUNC_CODE, {3'(i), b1[5:0]});
        end
        $display("test nonmem finished");
    endtask : t_nonmem

    task automatic t_memop();
        logic [7:0]  mb1 [4] = '{8'h07, 8'h46, 8'h9c, 8'h36};
        logic [15:0] md [4]  = '{16'h0000, 16'hfff0, 16'h1234, 16'h8000};
        logic [2:0]  ml [4]  = '{3'h2, 3'h3, 3'h4, 3'h4};
        logic [7:0]  op;
        com_addr_t   ea;
        for (int i = 0; i < 4; i++) begin
            op = {5'h1b, 3'(i + 4)};
            ea = 20'h0_4000 + {{4{md[i][15]}}, md[i]};
            run({md[i], mb1[i], op}, ml[i], 20'h0_4000, 16'h5a00 + 16'(i));
            check(saw[0], 1'b1);
            check(rd_addr, ea);
            check(saw[2], 1'b1);
            check(saw[1], 1'b0);
            check(saw[4], 1'b1);
            check(MEMOP_CODE, {op[2:0], mb1[i][5:3]});
            check(MEMOP_ADDR, ea);
            check(MEMOP_DATA, 16'h5a00 + 16'(i));
        end
        $display("test memop finished");
    endtask : t_memop

    task automatic t_foreign();
        run({24'h00_0000, 8'h90}, 3'h1, 20'h0_0000, 16'h0000);
        check(saw[2:1], 2'h0);
        check(saw[4], 1'b0);
        run({8'hd9, 8'hc0, 8'hd8, 8'hc7}, 3'h4, 20'h0_0000, 16'h0000);
        check(saw[2:1], 2'h0);
        check(saw[4], 1'b0);
        run({16'h0000, 8'hd1, 8'hda}, 3'h2, 20'h0_0000, 16'h0000);
        check(saw[1], 1'b1);
        check(FUNC_CODE, 9'h091);
        $display("test foreign finished");
    endtask : t_foreign

    task automatic t_stack();
        for (int i = 0; i < 8; i++) begin
            @(posedge CLK);
            STACK_WE    <= 1'b1;
            STACK_WSEL  <= 3'(i);
            STACK_WDATA <= {16{2'h2, 3'(i)}};
        end
        @(posedge CLK);
        STACK_WE <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            @(posedge CLK);
            STACK_RSEL <= 3'(i);
            @(posedge CLK);
            @(negedge CLK);
            check(STACK_RDATA, {16{2'h2, 3'(i)}});
        end
        $display("test stack finished");
    endtask : t_stack

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    // =================================================================
    // Main sequence and watchdog
    initial begin
        err_count   = 0;
        tests_run   = 0;
        exp_ip      = 20'h0_0000;
        saw         = 5'h00;
        RSTN        = 1'b0;
        INSTR_VALID = 1'b0;
        INSTR_BYTES = 32'h0000_0000;
        INSTR_LEN   = 3'h1;
        BASE_ADDR   = 20'h0_0000;
        MEM_RDATA   = 16'h0000;
        STACK_WE    = 1'b0;
        STACK_WSEL  = 3'h0;
        STACK_WDATA = 80'h0;
        STACK_RSEL  = 3'h0;
        repeat (5) @(posedge CLK);
        RSTN <= 1'b1;
        @(negedge CLK);
        check(IP_OUT, 20'h0_0000);
        check(BUSY, 1'b0);
        check(STACK_RDATA, 80'h0);
        check(com_if_inst.bus_cycle_status, `COM_BS_PASSIVE);
        t_nonmem();
        t_memop();
        t_foreign();
        t_stack();
        conclude();
    end

    initial begin
        #400000;
        err_count++;
        conclude();
    end

endmodule : tb
